/* File: design/fpt_cfg.svh */
// Constants for the flash page, sector guard and clock register block.
// Assumes inclusion by the register block and its bench only.
// Notes on behaviour
// - Page select picks one of 128 pages.
// - Page erase sets selected page to FFh.
// - Page field drives flash address [15:9].
// - Bit 7 maps information area at FE00h.
// - Guard selected hides page select register.
// - Guard reachable only after command 5Eh.
// - Guard bits only set by user writes.
// - Set guard bit blocks sector program, erase.
// - Clock value is high byte, low byte.
// - Operation durations derive from kHz value.
// - Bad or misordered command locks controller; commands are ignored during program, erase.
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH
// Printed register indices; the APB byte address is four times each.
`define FPT_IDX_COMMAND   12'hff8
`define FPT_IDX_PAGE      12'hff9
`define FPT_IDX_KHZ_HIGH  12'hffa
`define FPT_IDX_KHZ_LOW   12'hffb
// Command codes written to the command register.
`define FPT_CMD_LOCK      8'h00
`define FPT_CMD_UNLOCK1   8'h73
`define FPT_CMD_UNLOCK2   8'h8c
`define FPT_CMD_ERASE     8'h95
`define FPT_CMD_GUARD     8'h5e
// Status codes read back at the command register.
`define FPT_ST_LOCKED     8'h00
`define FPT_ST_FIRST      8'h01
`define FPT_ST_SECOND     8'h02
`define FPT_ST_UNLOCKED   8'h03
`define FPT_ST_GUARD      8'h04
`define FPT_ST_PROGRAM    8'h08
`define FPT_ST_ERASE      8'h10
// Field positions of the page selection register.
`define FPT_INFO_BIT      7
`define FPT_PAGE_MSB      6
// Reset values.
`define FPT_RST_BYTE      8'h00
// Durations of flash operations in microseconds.
`define FPT_PROG_TIME_US  16'h0028
`define FPT_ERASE_TIME_US 16'h2710
// Kilohertz times microseconds over this gives clock cycles.
`define FPT_US_PER_MS     32'h0000_03e8
`endif

/* File: design/fpt_pkg.sv */
// Types shared by the flash register block and its timer.
// Assumes the constants header sits beside it.
package fpt_pkg;
    // Controller states; codes are left to the tools.
    typedef enum logic [2:0]
    {
        FPT_LOCKED,
        FPT_FIRST,
        FPT_SECOND,
        FPT_UNLOCKED,
        FPT_GUARD_SEL,
        FPT_PROGRAM,
        FPT_ERASE
    } fpt_state_type;
    // Program request from the CPU memory path.
    typedef struct packed
    {
        logic        req;
        logic [15:0] addr;
    } fpt_prog_req_type;
    // Signals towards the flash array.
    typedef struct packed
    {
        logic [6:0]  page;
        logic        info_sel;
        logic [7:0]  guard;
        logic        prog_busy;
        logic        erase_busy;
        logic        op_done;
        logic        refused;
    } fpt_flash_out_type;
endpackage

/* File: design/fpt_op_timer.sv */
// Cycle counter that times one flash program or erase operation.
// Assumes a start pulse with the cycle count valid in the same cycle.
`timescale 1ns/1ps
module fpt_op_timer
    import fpt_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [31:0] cycles,
    output logic             busy,
    output logic             done
);
    // Remaining cycles of the running operation.
    logic [31:0] remain_reg;

    // A count of zero still lasts one cycle, so done always follows.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            remain_reg <= 32'h0000_0000;
            busy       <= 1'b0;
            done       <= 1'b0;
        end
        else if (start && !busy)
        begin
            // Start is ignored while an operation runs.
            remain_reg <= (cycles == 32'h0000_0000) ? 32'h0000_0000
                                                    : cycles - 32'h1;
            busy       <= 1'b1;
            done       <= 1'b0;
        end
        else if (busy && remain_reg == 32'h0000_0000)
        begin
            busy <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            remain_reg <= busy ? remain_reg - 32'h1 : remain_reg;
            done       <= 1'b0;
        end
    end
endmodule

/* File: design/fpt_regs.sv */
// APB register block for flash page select, sector guard and clock value.
// Assumes an APB master on pclk and a flash array that obeys flash_out.
`timescale 1ns/1ps
`include "fpt_cfg.svh"
module fpt_regs
    import fpt_pkg::*;
#(
    parameter int SECTOR_SHIFT  = 4,
    parameter int PROG_TIME_US  = 40,
    parameter int ERASE_TIME_US = 10000
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire fpt_prog_req_type  prog_in,
    output fpt_flash_out_type      flash_out
);
    // Byte addresses derived from the printed indices.
    localparam logic [15:0] ADDR_CMD  = {2'b00, `FPT_IDX_COMMAND, 2'b00};
    localparam logic [15:0] ADDR_PAGE = {2'b00, `FPT_IDX_PAGE, 2'b00};
    localparam logic [15:0] ADDR_KHI  = {2'b00, `FPT_IDX_KHZ_HIGH, 2'b00};
    localparam logic [15:0] ADDR_KLO  = {2'b00, `FPT_IDX_KHZ_LOW, 2'b00};

    fpt_state_type state_reg;        // Controller state.
    logic [7:0]    page_reg;         // Page selection register.
    logic [7:0]    guard_reg;        // Sector guard register.
    logic [7:0]    khz_high_reg;     // Clock value, high byte.
    logic [7:0]    khz_low_reg;      // Clock value, low byte.
    logic [15:0]   clock_khz_value;  // Joined clock value.
    logic          access;           // Access phase completes now.
    logic          wr_cmd;           // Command register written.
    logic          wr_page;          // Shared address written.
    logic          mapped;           // Address decodes to a register.
    logic [7:0]    rd_byte;          // Read value of the addressed byte.
    logic [7:0]    status_code;      // State as a status code.
    logic [7:0]    cmd;              // Written command byte.
    logic [2:0]    page_sector;      // Sector of the selected page.
    logic [2:0]    prog_sector;      // Sector of the program address.
    logic          page_guarded;     // Selected page is protected.
    logic          prog_ok;          // Program request may start.
    logic          erase_ok;         // Erase command may start.
    logic          tmr_start;        // Start the operation timer.
    logic [31:0]   tmr_cycles;       // Cycles the operation lasts.
    logic [31:0]   prog_cycles;      // Program duration in cycles.
    logic [31:0]   erase_cycles;     // Erase duration in cycles.
    logic          tmr_busy;         // Timer running.
    logic          tmr_done;         // Timer finished this cycle.

    // The access completes in the cycle after pready was raised.
    assign access  = psel && penable && pready;
    assign cmd     = pwdata[7:0];
    assign wr_cmd  = access && pwrite && paddr == ADDR_CMD;
    assign wr_page = access && pwrite && paddr == ADDR_PAGE;
    // Only the four words answer; any other word ends in an error.
    assign mapped  = paddr == ADDR_CMD || paddr == ADDR_PAGE ||
                     paddr == ADDR_KHI || paddr == ADDR_KLO;

    assign clock_khz_value = {khz_high_reg, khz_low_reg};

    assign page_sector  = 3'(page_reg[`FPT_PAGE_MSB:0] >> SECTOR_SHIFT);
    assign prog_sector  = 3'(prog_in.addr[15:9] >> SECTOR_SHIFT);
    assign page_guarded = guard_reg[page_sector];
    assign prog_ok      = prog_in.req && state_reg == FPT_UNLOCKED &&
                          prog_in.addr[15:9] == page_reg[`FPT_PAGE_MSB:0] &&
                          !guard_reg[prog_sector];
    assign erase_ok     = wr_cmd && cmd == `FPT_CMD_ERASE &&
                          state_reg == FPT_UNLOCKED && !page_guarded;

    // Durations scale with the kHz value; the cast keeps 32 bits.
    assign prog_cycles  = 32'(clock_khz_value * 32'(PROG_TIME_US)
                              / `FPT_US_PER_MS);
    assign erase_cycles = 32'(clock_khz_value * 32'(ERASE_TIME_US)
                              / `FPT_US_PER_MS);
    assign tmr_start    = (prog_ok || erase_ok) && !tmr_busy;
    assign tmr_cycles   = erase_ok ? erase_cycles : prog_cycles;

    // Status code for reads of the command address.
    always_comb
    begin
        case (state_reg)
            FPT_FIRST:     status_code = `FPT_ST_FIRST;
            FPT_SECOND:    status_code = `FPT_ST_SECOND;
            FPT_UNLOCKED:  status_code = `FPT_ST_UNLOCKED;
            FPT_GUARD_SEL: status_code = `FPT_ST_GUARD;
            FPT_PROGRAM:   status_code = `FPT_ST_PROGRAM;
            FPT_ERASE:     status_code = `FPT_ST_ERASE;
            default:       status_code = `FPT_ST_LOCKED;
        endcase
    end

    // Read multiplexer; the shared address shows the guard when selected.
    always_comb
    begin
        rd_byte = `FPT_RST_BYTE;
        if (paddr == ADDR_CMD)
            rd_byte = status_code;
        else if (paddr == ADDR_PAGE)
            rd_byte = (state_reg == FPT_GUARD_SEL) ? guard_reg : page_reg;
        else if (paddr == ADDR_KHI)
            rd_byte = khz_high_reg;
        else if (paddr == ADDR_KLO)
            rd_byte = khz_low_reg;
    end

    // APB handshake: one wait state, so every access takes three edges.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            // Unmapped addresses answer with an error and read zero.
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= (psel && penable && !pready && !pwrite) ?
                       {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Command sequencer; writes are ignored while an operation runs.
    // Busy states last one cycle past the timer, as its done is registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= FPT_LOCKED;
        else if (state_reg == FPT_ERASE)
        begin
            // Erase ends locked.
            if (tmr_done)
                state_reg <= FPT_LOCKED;
        end
        else if (state_reg == FPT_PROGRAM)
        begin
            if (tmr_done)
                state_reg <= FPT_UNLOCKED;
        end
        else if (wr_cmd)
        begin
            state_reg <= FPT_LOCKED;
            if (state_reg == FPT_LOCKED && cmd == `FPT_CMD_UNLOCK1)
                state_reg <= FPT_FIRST;
            else if (state_reg == FPT_FIRST && cmd == `FPT_CMD_UNLOCK2)
                state_reg <= FPT_SECOND;
            else if (state_reg == FPT_LOCKED && cmd == `FPT_CMD_GUARD)
                state_reg <= FPT_GUARD_SEL;
            else if (erase_ok)
                state_reg <= FPT_ERASE;
        end
        else if (wr_page && state_reg == FPT_SECOND)
        begin
            // The page rewrite must match the page written before unlock.
            state_reg <= (cmd == page_reg) ? FPT_UNLOCKED : FPT_LOCKED;
        end
        else if (prog_ok)
            state_reg <= FPT_PROGRAM;
    end

    // Page selection; frozen once unlocked so one page stays open.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            page_reg <= `FPT_RST_BYTE;
        else if (wr_page && (state_reg == FPT_LOCKED ||
                             state_reg == FPT_FIRST))
            page_reg <= cmd;
    end

    // Sector guard; only reset can clear a bit.
    // User code has no clearing path, so a wrong guard needs a reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            guard_reg <= `FPT_RST_BYTE;
        // Bits only go from 0 to 1.
        else if (wr_page && state_reg == FPT_GUARD_SEL)
            guard_reg <= guard_reg | cmd;
    end

    // Clock value bytes, plain read-write.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            khz_high_reg <= `FPT_RST_BYTE;
            khz_low_reg  <= `FPT_RST_BYTE;
        end
        else if (access && pwrite)
        begin
            if (paddr == ADDR_KHI)
                khz_high_reg <= cmd;
            if (paddr == ADDR_KLO)
                khz_low_reg <= cmd;
        end
    end

    // Flash side outputs, all registered.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flash_out <= '0;
        else
        begin
            // One of 128 pages of 512 bytes.
            flash_out.page       <= page_reg[`FPT_PAGE_MSB:0];
            flash_out.info_sel   <= page_reg[`FPT_INFO_BIT];
            flash_out.guard      <= guard_reg;
            flash_out.prog_busy  <= state_reg == FPT_PROGRAM;
            flash_out.erase_busy <= state_reg == FPT_ERASE;
            flash_out.op_done    <= tmr_done;
            flash_out.refused    <= (prog_in.req && !prog_ok) ||
                                    (wr_cmd && cmd == `FPT_CMD_ERASE &&
                                     !erase_ok);
        end
    end

    // The operation timer measures program and erase durations.
    // Only one operation runs at a time, so one timer serves both.
    fpt_op_timer fpt_op_timer_inst
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (tmr_start),
        .cycles  (tmr_cycles),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Rule checks; all run on pclk and rest while reset is low.
    guard_sticky_a: assert property
        ((guard_reg & $past(guard_reg)) == $past(guard_reg))
        else $error("Guard bit cleared.");
    guard_gate_a: assert property
        (state_reg != FPT_GUARD_SEL |=> $stable(guard_reg))
        else $error("Guard changed while not selected.");
    page_hidden_a: assert property
        (state_reg == FPT_GUARD_SEL |=> $stable(page_reg))
        else $error("Page select written while guard selected.");
    page_addr_a: assert property
        (1'b1 |=> flash_out.page == $past(page_reg[6:0]))
        else $error("Flash page does not follow page field.");
    info_map_a: assert property
        (##1 flash_out.info_sel == $past(page_reg[7]))
        else $error("Information select wrong.");
    bad_cmd_a: assert property
        (wr_cmd && state_reg == FPT_FIRST && cmd != `FPT_CMD_UNLOCK2
         |=> state_reg == FPT_LOCKED)
        else $error("Out-of-order command did not lock.");
    guard_block_a: assert property
        (prog_in.req && state_reg == FPT_UNLOCKED &&
         guard_reg[prog_sector] |=> state_reg != FPT_PROGRAM)
        else $error("Program started in guarded sector.");
    guard_read_a: assert property
        (psel && penable && !pready && !pwrite && paddr == ADDR_PAGE &&
         state_reg == FPT_GUARD_SEL |=> prdata[7:0] == $past(guard_reg))
        else $error("Shared address did not show the guard.");
    erase_end_a: assert property
        (state_reg == FPT_ERASE && tmr_done |=> state_reg == FPT_LOCKED)
        else $error("Erase did not end locked.");
    khz_join_a: assert property
        (access && pwrite && paddr == ADDR_KHI
         |=> clock_khz_value[15:8] == $past(pwdata[7:0]))
        else $error("High byte not placed first.");
    short_op_a: assert property
        (tmr_start && tmr_cycles == 32'h0000_0000
         |=> tmr_busy ##1 (!tmr_busy && tmr_done))
        else $error("Shortest operation timing wrong.");

    // Main scenarios: unlock, erase to lock, guard, program, refusal.
    unlock_c: cover property
        (state_reg == FPT_SECOND ##[1:20] state_reg == FPT_UNLOCKED);
    erase_c: cover property
        (state_reg == FPT_ERASE ##[1:300] state_reg == FPT_LOCKED);
    guard_c: cover property (wr_page && state_reg == FPT_GUARD_SEL);
    prog_c: cover property (prog_ok);
    refuse_c: cover property (flash_out.refused);
endmodule

/* File: test/fpt_regs_bench.sv */
// Self-checking bench for the flash page, sector guard and clock block.
// Assumes the design package and the constants header are compiled first.
`timescale 1ns/1ps
`include "fpt_cfg.svh"
`define CHK(a, e) \
begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
        mismatches++; \
    end \
end
module fpt_regs_bench;
    import fpt_pkg::*;
    // Byte addresses are four times the register indices.
    localparam logic [15:0] A_CMD = {2'b00, `FPT_IDX_COMMAND, 2'b00};
    localparam logic [15:0] A_PAGE = {2'b00, `FPT_IDX_PAGE, 2'b00};
    localparam logic [15:0] A_KHI = {2'b00, `FPT_IDX_KHZ_HIGH, 2'b00};
    localparam logic [15:0] A_KLO = {2'b00, `FPT_IDX_KHZ_LOW, 2'b00};
    logic              pclk;          // System clock, 100 MHz.
    logic              presetn;       // Asynchronous reset, active low.
    logic              psel;          // APB select.
    logic              penable;       // APB access phase.
    logic              pwrite;        // APB direction.
    logic [15:0]       paddr;         // APB byte address.
    logic [31:0]       pwdata;        // APB write data.
    logic [31:0]       prdata;        // APB read data.
    logic              pready;        // APB completion.
    logic              pslverr;       // APB error.
    fpt_prog_req_type  prog_in;       // Program request from the CPU.
    fpt_flash_out_type flash_out;     // Signals towards the flash array.
    int                mismatches;    // Failed comparisons.
    int                total_checks;  // Comparisons made.
    int                erase_cycles;  // Cycles with erase busy seen.
    int                prog_cycles;   // Cycles with program busy seen.
    int                done_pulses;   // Completion pulses seen.
    int                refusals;      // Refusal pulses seen.
    int                base;          // Snapshot of a counter.
    fpt_regs fpt_regs_inst
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .prog_in   (prog_in),
        .flash_out (flash_out)
    );
    // Free-running clock with a 10 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Pulse and busy counters; pulses last one cycle so counting is exact.
    always @(posedge pclk)
    begin
        if (flash_out.erase_busy === 1'b1)
            erase_cycles++;
        if (flash_out.prog_busy === 1'b1)
            prog_cycles++;
        if (flash_out.op_done === 1'b1)
            done_pulses++;
        if (flash_out.refused === 1'b1)
            refusals++;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One APB transfer; waits for pready with a bound, never a fixed count.
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            mismatches++;
    endtask
    // Register write that must not raise an error.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask
    // Register read compared against an expected byte.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        `CHK(r, {24'h000000, x})
        `CHK(e, 1'b0)
    endtask
    // Full unlock: lock, page, two unlock codes, page again.
    task automatic unlock(input logic [7:0] p);
        wr(A_CMD, `FPT_CMD_LOCK);
        wr(A_PAGE, p);
        wr(A_CMD, `FPT_CMD_UNLOCK1);
        wr(A_CMD, `FPT_CMD_UNLOCK2);
        wr(A_PAGE, p);
    endtask
    // One-cycle program request; the short wait covers refusal and the
    // minimum program time, both fixed at a few cycles by the design.
    task automatic prog(input logic [15:0] a);
        @(posedge pclk);
        prog_in <= {1'b1, a};
        @(posedge pclk);
        prog_in <= {1'b0, 16'h0000};
        repeat (8) @(posedge pclk);
    endtask
    // Waits for the next completion pulse under a bound.
    task automatic wait_done(input int from);
        int n;
        n = 0;
        while (done_pulses == from && n < 500)
        begin
            @(posedge pclk);
            n++;
        end
        `CHK(done_pulses, from + 1)
    endtask
    // Watchdog; the whole sequence needs well under 2000 cycles.
    initial
    begin
        #200000;
        mismatches++;
        summarize();
    end
    // Main sequence.
    initial
    begin
        logic [31:0] r;
        logic        e;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        prog_in = '0;
        {mismatches, total_checks, erase_cycles, prog_cycles} = '0;
        {done_pulses, refusals, base} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of the page and clock registers and of the status.
        rd_chk(A_CMD, `FPT_ST_LOCKED);
        rd_chk(A_PAGE, 8'h00);
        rd_chk(A_KHI, 8'h00);
        rd_chk(A_KLO, 8'h00);
        // An unmapped word answers with an error and reads zero.
        apb(1'b0, 16'h3ff0, 8'h00, r, e);
        `CHK(e, 1'b1)
        `CHK(r, 32'h00000000)
        // Both frequency bytes hold distinct values independently.
        wr(A_KHI, 8'ha5);
        wr(A_KLO, 8'h5a);
        rd_chk(A_KHI, 8'ha5);
        rd_chk(A_KLO, 8'h5a);
        // The lowest supported value, 20 kHz, keeps the erase short.
        wr(A_KHI, 8'h00);
        wr(A_KLO, 8'h14);
        // Page field and information-area bit reach the flash side.
        wr(A_PAGE, 8'h85);
        rd_chk(A_PAGE, 8'h85);
        @(negedge pclk);
        `CHK(flash_out.page, 7'h05)
        `CHK(flash_out.info_sel, 1'b1)
        // Guard select hides the page register; bits only ever set.
        wr(A_CMD, `FPT_CMD_GUARD);
        rd_chk(A_CMD, `FPT_ST_GUARD);
        rd_chk(A_PAGE, 8'h00);
        wr(A_PAGE, 8'h01);
        wr(A_PAGE, 8'h00);
        rd_chk(A_PAGE, 8'h01);
        wr(A_PAGE, 8'h04);
        rd_chk(A_PAGE, 8'h05);
        @(negedge pclk);
        `CHK(flash_out.guard, 8'h05)
        wr(A_CMD, `FPT_CMD_LOCK);
        rd_chk(A_PAGE, 8'h85);
        // Repeated first code and a lone second code both lock again.
        wr(A_CMD, `FPT_CMD_UNLOCK1);
        rd_chk(A_CMD, `FPT_ST_FIRST);
        wr(A_CMD, `FPT_CMD_UNLOCK1);
        rd_chk(A_CMD, `FPT_ST_LOCKED);
        wr(A_CMD, `FPT_CMD_UNLOCK2);
        rd_chk(A_CMD, `FPT_ST_LOCKED);
        // Page 5 lies in guarded sector 0: program and erase are denied.
        unlock(8'h05);
        rd_chk(A_CMD, `FPT_ST_UNLOCKED);
        base = refusals;
        prog({7'h05, 9'h000});
        `CHK(refusals, base + 1)
        wr(A_CMD, `FPT_CMD_ERASE);
        repeat (4) @(posedge pclk);
        `CHK(erase_cycles, 0)
        // Page 16 lies in open sector 1; a write to page 17 is denied.
        unlock(8'h10);
        base = refusals;
        prog({7'h11, 9'h000});
        `CHK(refusals, base + 1)
        base = done_pulses;
        prog({7'h10, 9'h1ff});
        `CHK(done_pulses, base + 1)
        // Shortest program: one timer cycle plus the cycle seeing done.
        `CHK(prog_cycles, 2)
        rd_chk(A_CMD, `FPT_ST_UNLOCKED);
        // Erase runs 10 cycles per kHz, one more to see done, then locks.
        base = done_pulses;
        wr(A_CMD, `FPT_CMD_ERASE);
        rd_chk(A_CMD, `FPT_ST_ERASE);
        wait_done(base);
        `CHK(erase_cycles, 20 * 10 + 1)
        rd_chk(A_CMD, `FPT_ST_LOCKED);
        summarize();
    end
endmodule
